// *** design/ter_pkg.sv ***
// shared constants, types and helpers for the trigger event recognizer
package ter_pkg;
	// one probed sample: address, data and control sections
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] data;
		logic [31:0] addr;
	} ter_sample_t;

	typedef enum logic [2:0] {
		RG_IN, RG_NOT_IN, RG_EQ, RG_NE, RG_GT, RG_GE, RG_LT, RG_LE
	} ter_range_op_t;
	typedef enum logic [1:0] {LV_ASSERTED, LV_UNASSERTED, LV_DONT_CARE} ter_level_t;
	typedef enum logic [1:0] {CS_SECTIONS, CS_GROUPS, CS_GROUP} ter_consec_t;

	localparam int WORD_N = 4;
	localparam int CLAUSE_N = 8;
	localparam int CLAUSE_MAX_EV = 8;
	localparam int EV_N = 14;
	localparam int CHAN_N = 96;
	// event vector bit positions
	localparam int EV_WORD0 = 0;
	localparam int EV_RANGE = 4;
	localparam int EV_CHAN = 5;
	localparam int EV_CNT0 = 6;
	localparam int EV_TMR0 = 8;
	localparam int EV_FLAG = 10;
	localparam int EV_SIG = 11;
	localparam int EV_CONSEC = 12;
	localparam int EV_ANY = 13;

	// register byte offsets
	localparam logic [11:0] OFS_MODE_CFG = 12'h000;
	localparam logic [11:0] OFS_RANGE_LIM1 = 12'h004;
	localparam logic [11:0] OFS_RANGE_LIM2 = 12'h008;
	localparam logic [11:0] OFS_RANGE_MASK = 12'h00C;
	localparam logic [11:0] OFS_CNT_TGT0 = 12'h010;
	localparam logic [11:0] OFS_CNT_TGT1 = 12'h014;
	localparam logic [11:0] OFS_TMR_TGT0 = 12'h018;
	localparam logic [11:0] OFS_TMR_TGT1 = 12'h01C;
	localparam logic [11:0] OFS_QUAL0 = 12'h020;
	localparam logic [11:0] OFS_QUAL1 = 12'h024;
	localparam logic [11:0] OFS_QUAL2 = 12'h028;
	localparam logic [11:0] OFS_STATUS = 12'h02C;
	localparam logic [11:0] OFS_CLAUSE0 = 12'h040;
	localparam logic [11:0] OFS_WORD0 = 12'h080;
	localparam logic [11:0] WORD_STRIDE = 12'h020;

	// mode_cfg field positions, then the clause_cfg or bit
	localparam int RANGE_OP_POS = 0;
	localparam int RANGE_SRC_POS = 3;
	localparam int HS_MODE_POS = 4;
	localparam int CHAN_SEL_POS = 5;
	localparam int CHAN_COND_POS = 12;
	localparam int FLAG_COND_POS = 14;
	localparam int SIG_SEL_POS = 16;
	localparam int SIG_COND_POS = 18;
	localparam int CONSEC_SEL_POS = 20;
	localparam int CONSEC_NE_POS = 22;
	localparam int CNT_LT_POS = 23;
	localparam int TMR_LT_POS = 25;
	localparam int WORD_NE_POS = 27;
	localparam int CLAUSE_OR_POS = 16;

	// reset values; timer counts 10 ns ticks, least target 70 ns
	localparam int TIMER_TICK_NS = 10;
	localparam int TIMER_MIN_NS = 70;
	localparam logic [31:0] MODE_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] LIM1_RST = 32'h0000_0000;
	localparam logic [31:0] LIM2_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] RANGE_MASK_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] CNT_TGT_RST = 32'h0000_0001;
	localparam logic [31:0] TMR_TGT_RST = 32'(TIMER_MIN_NS / TIMER_TICK_NS);
	localparam logic [31:0] WORD_CARE_RST = 32'h0000_0000;
	localparam logic [31:0] ZERO_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// level test shared by channel, flag and signal events
	function automatic logic level_test(input logic [1:0] cond, input logic lvl);
		unique case (cond)
			LV_ASSERTED: level_test = lvl;
			LV_UNASSERTED: level_test = !lvl;
			LV_DONT_CARE: level_test = 1'b1;
			default: level_test = 1'b0;
		endcase
	endfunction

	// count test shared by both counters and both timers
	function automatic logic count_test(input logic lt, input logic [31:0] v,
		input logic [31:0] tgt);
		count_test = lt ? (v < tgt) : (v >= tgt);
	endfunction
endpackage

// *** design/ter_recognizer.sv ***
// trigger event recognizer with its axi4-lite register file
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module ter_recognizer (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// probed channels and sample enable
	input wire ter_pkg::ter_sample_t smp,
	input wire logic sample_en,
	// state kept by the trigger actions outside
	input wire logic trig_flag,
	input wire logic [3:0] mod_sig,
	input wire logic [31:0] cnt_val0,
	input wire logic [31:0] cnt_val1,
	input wire logic [31:0] tmr_val0,
	input wire logic [31:0] tmr_val1,
	// results toward the trigger state machine
	output logic [ter_pkg::EV_N-1:0] event_hit,
	output logic [ter_pkg::CLAUSE_N-1:0] clause_hit
);
	// configuration registers
	logic [31:0] mode_cfg;
	logic [31:0] range_lim1;
	logic [31:0] range_lim2;
	logic [31:0] range_mask;
	logic [31:0] cnt_tgt [2];
	logic [31:0] tmr_tgt [2];
	logic [31:0] qual_mask [3];
	logic [31:0] clause_cfg [ter_pkg::CLAUSE_N];
	// per comparator: value addr/data/ctrl then care addr/data/ctrl
	logic [31:0] word_reg [ter_pkg::WORD_N][6];

	// bus holding state
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	// sample history for the consecutive-cycle event
	ter_pkg::ter_sample_t prev_smp;
	logic prev_valid;

	// register lookup: {hit, value}; shared by read and write merge
	function automatic logic [32:0] reg_lookup(input logic [11:0] a);
		logic [2:0] k;
		logic [1:0] id;
		k = a[4:2];
		id = a[6:5];
		reg_lookup = {1'b1, 32'h0000_0000};
		if (a[11:7] == ter_pkg::OFS_WORD0[11:7]) begin
			if (k < 3'h6) begin
				reg_lookup[31:0] = word_reg[id][k];
			end else begin
				reg_lookup[32] = 1'b0;
			end
		end else if (a[11:5] == ter_pkg::OFS_CLAUSE0[11:5]) begin
			reg_lookup[31:0] = clause_cfg[k];
		end else begin
			unique case (a)
				ter_pkg::OFS_MODE_CFG: reg_lookup[31:0] = mode_cfg;
				ter_pkg::OFS_RANGE_LIM1: reg_lookup[31:0] = range_lim1;
				ter_pkg::OFS_RANGE_LIM2: reg_lookup[31:0] = range_lim2;
				ter_pkg::OFS_RANGE_MASK: reg_lookup[31:0] = range_mask;
				ter_pkg::OFS_CNT_TGT0: reg_lookup[31:0] = cnt_tgt[0];
				ter_pkg::OFS_CNT_TGT1: reg_lookup[31:0] = cnt_tgt[1];
				ter_pkg::OFS_TMR_TGT0: reg_lookup[31:0] = tmr_tgt[0];
				ter_pkg::OFS_TMR_TGT1: reg_lookup[31:0] = tmr_tgt[1];
				ter_pkg::OFS_QUAL0: reg_lookup[31:0] = qual_mask[0];
				ter_pkg::OFS_QUAL1: reg_lookup[31:0] = qual_mask[1];
				ter_pkg::OFS_QUAL2: reg_lookup[31:0] = qual_mask[2];
				ter_pkg::OFS_STATUS: reg_lookup[31:0] = {8'h00, clause_hit, 2'h0, event_hit};
				default: reg_lookup[32] = 1'b0;
			endcase
		end
	endfunction

	// write channels: each held until both are in, then one response
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	logic [32:0] wr_look;
	// a process, not an assign, so a register change behind the lookup is seen
	always_comb wr_look = reg_lookup({aw_addr_q[11:2], 2'h0});
	wire wr_ok = wr_look[32] && (aw_addr_q[11:2] != ter_pkg::OFS_STATUS[11:2]);
	wire [31:0] wr_merged;
	// byte lanes not strobed keep their old value
	genvar b;
	for (b = 0; b < 4; b++) begin : g_lane
		assign wr_merged[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] : wr_look[b*8 +: 8];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ter_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? ter_pkg::RESP_OKAY : ter_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read: answer one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;
	logic [32:0] rd_look;
	// status and registers move under a steady address, so track them too
	always_comb rd_look = reg_lookup({s_axi_araddr[11:2], 2'h0});
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ter_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_look[31:0];
			s_axi_rresp <= rd_look[32] ? ter_pkg::RESP_OKAY : ter_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// register file; word care masks reset to zero so a new comparator matches all
	wire wr_en = do_write && wr_ok;
	wire wr_word = aw_addr_q[11:7] == ter_pkg::OFS_WORD0[11:7];
	wire wr_clause = aw_addr_q[11:5] == ter_pkg::OFS_CLAUSE0[11:5];
	wire [11:0] wr_a = {aw_addr_q[11:2], 2'h0};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_cfg <= ter_pkg::MODE_CFG_RST;
			range_lim1 <= ter_pkg::LIM1_RST;
			range_lim2 <= ter_pkg::LIM2_RST;
			range_mask <= ter_pkg::RANGE_MASK_RST;
			for (int i = 0; i < 2; i++) begin
				cnt_tgt[i] <= ter_pkg::CNT_TGT_RST;
				tmr_tgt[i] <= ter_pkg::TMR_TGT_RST;
			end
			for (int i = 0; i < 3; i++) begin
				qual_mask[i] <= ter_pkg::ZERO_RST;
			end
			for (int i = 0; i < ter_pkg::CLAUSE_N; i++) begin
				clause_cfg[i] <= ter_pkg::ZERO_RST;
			end
			for (int i = 0; i < ter_pkg::WORD_N; i++) begin
				for (int k = 0; k < 6; k++) begin
					word_reg[i][k] <= k < 3 ? ter_pkg::ZERO_RST : ter_pkg::WORD_CARE_RST;
				end
			end
		end else if (wr_en && wr_word) begin
			word_reg[aw_addr_q[6:5]][aw_addr_q[4:2]] <= wr_merged;
		end else if (wr_en && wr_clause) begin
			clause_cfg[aw_addr_q[4:2]] <= wr_merged;
		end else if (wr_en) begin
			unique case (wr_a)
				ter_pkg::OFS_MODE_CFG: mode_cfg <= wr_merged;
				ter_pkg::OFS_RANGE_LIM1: range_lim1 <= wr_merged;
				ter_pkg::OFS_RANGE_LIM2: range_lim2 <= wr_merged;
				ter_pkg::OFS_RANGE_MASK: range_mask <= wr_merged;
				ter_pkg::OFS_CNT_TGT0: cnt_tgt[0] <= wr_merged;
				ter_pkg::OFS_CNT_TGT1: cnt_tgt[1] <= wr_merged;
				ter_pkg::OFS_TMR_TGT0: tmr_tgt[0] <= wr_merged;
				ter_pkg::OFS_TMR_TGT1: tmr_tgt[1] <= wr_merged;
				ter_pkg::OFS_QUAL0: qual_mask[0] <= wr_merged;
				ter_pkg::OFS_QUAL1: qual_mask[1] <= wr_merged;
				ter_pkg::OFS_QUAL2: qual_mask[2] <= wr_merged;
				default: mode_cfg <= mode_cfg;
			endcase
		end
	end

	// mode field decode
	wire [2:0] range_op = mode_cfg[ter_pkg::RANGE_OP_POS +: 3];
	wire range_src = mode_cfg[ter_pkg::RANGE_SRC_POS];
	wire hs_mode = mode_cfg[ter_pkg::HS_MODE_POS];
	wire [6:0] chan_sel = mode_cfg[ter_pkg::CHAN_SEL_POS +: 7];
	wire [1:0] chan_cond = mode_cfg[ter_pkg::CHAN_COND_POS +: 2];
	wire [1:0] flag_cond = mode_cfg[ter_pkg::FLAG_COND_POS +: 2];
	wire [1:0] sig_sel = mode_cfg[ter_pkg::SIG_SEL_POS +: 2];
	wire [1:0] sig_cond = mode_cfg[ter_pkg::SIG_COND_POS +: 2];
	wire [1:0] consec_sel = mode_cfg[ter_pkg::CONSEC_SEL_POS +: 2];
	wire consec_ne = mode_cfg[ter_pkg::CONSEC_NE_POS];

	wire [ter_pkg::EV_N-1:0] ev_now;
	wire [ter_pkg::CLAUSE_N-1:0] clause_now;

	// word comparators, one per identifier
	genvar w;
	for (w = 0; w < ter_pkg::WORD_N; w++) begin : g_word
		ter_word_cmp u_cmp (
			.aclk(aclk),
			.aresetn(aresetn),
			.smp(smp),
			.target({word_reg[w][2], word_reg[w][1], word_reg[w][0]}),
			.care({word_reg[w][5], word_reg[w][4], word_reg[w][3]}),
			.ne(mode_cfg[ter_pkg::WORD_NE_POS + w]),
			.hit(ev_now[ter_pkg::EV_WORD0 + w])
		);
	end

	// range: masked group, bounds sorted so either field may hold the low one
	wire [31:0] range_val = (range_src ? smp.data : smp.addr) & range_mask;
	wire [31:0] range_lo = range_lim1 <= range_lim2 ? range_lim1 : range_lim2;
	wire [31:0] range_hi = range_lim1 <= range_lim2 ? range_lim2 : range_lim1;
	wire range_inside = range_val >= range_lo && range_val <= range_hi;
	logic range_match;
	always_comb begin
		unique case (range_op)
			ter_pkg::RG_IN: range_match = range_inside;
			ter_pkg::RG_NOT_IN: range_match = !range_inside;
			ter_pkg::RG_EQ: range_match = range_val == range_lim1;
			ter_pkg::RG_NE: range_match = range_val != range_lim1;
			ter_pkg::RG_GT: range_match = range_val > range_lim1;
			ter_pkg::RG_GE: range_match = range_val >= range_lim1;
			ter_pkg::RG_LT: range_match = range_val < range_lim1;
			ter_pkg::RG_LE: range_match = range_val <= range_lim1;
		endcase
	end
	// the fast timing path has no range hardware, so the event is held off
	assign ev_now[ter_pkg::EV_RANGE] = range_match && !hs_mode;

	// single channel, flag and inter-module signal levels
	wire [ter_pkg::CHAN_N-1:0] smp_flat = smp;
	wire chan_level = chan_sel < 7'(ter_pkg::CHAN_N) ? smp_flat[chan_sel] : 1'b0;
	assign ev_now[ter_pkg::EV_CHAN] = ter_pkg::level_test(chan_cond, chan_level);
	assign ev_now[ter_pkg::EV_FLAG] = ter_pkg::level_test(flag_cond, trig_flag);
	assign ev_now[ter_pkg::EV_SIG] = ter_pkg::level_test(sig_cond, mod_sig[sig_sel]);

	// counters and timers against 32-bit targets; timer ticks are 10 ns
	assign ev_now[ter_pkg::EV_CNT0] =
		ter_pkg::count_test(mode_cfg[ter_pkg::CNT_LT_POS], cnt_val0, cnt_tgt[0]);
	assign ev_now[ter_pkg::EV_CNT0 + 1] =
		ter_pkg::count_test(mode_cfg[ter_pkg::CNT_LT_POS + 1], cnt_val1, cnt_tgt[1]);
	assign ev_now[ter_pkg::EV_TMR0] =
		ter_pkg::count_test(mode_cfg[ter_pkg::TMR_LT_POS], tmr_val0, tmr_tgt[0]);
	assign ev_now[ter_pkg::EV_TMR0 + 1] =
		ter_pkg::count_test(mode_cfg[ter_pkg::TMR_LT_POS + 1], tmr_val1, tmr_tgt[1]);

	// consecutive cycles: one shared selection, false until a first sample exists
	wire [ter_pkg::CHAN_N-1:0] grp_mask = range_src ? {32'h0000_0000, range_mask, 32'h0000_0000}
		: {64'h0000_0000_0000_0000, range_mask};
	wire [ter_pkg::CHAN_N-1:0] consec_mask =
		consec_sel == ter_pkg::CS_SECTIONS ? {ter_pkg::CHAN_N{1'b1}} :
		consec_sel == ter_pkg::CS_GROUPS ? {qual_mask[2], qual_mask[1], qual_mask[0]} :
		consec_sel == ter_pkg::CS_GROUP ? grp_mask : '0;
	wire consec_same = ((smp_flat ^ prev_smp) & consec_mask) == '0;
	assign ev_now[ter_pkg::EV_CONSEC] = prev_valid && (consec_same ^ consec_ne);

	assign ev_now[ter_pkg::EV_ANY] = 1'b1;

	// clauses: an empty selection never fires
	genvar c;
	for (c = 0; c < ter_pkg::CLAUSE_N; c++) begin : g_clause
		wire [ter_pkg::EV_N-1:0] sel = clause_cfg[c][ter_pkg::EV_N-1:0];
		wire use_or = clause_cfg[c][ter_pkg::CLAUSE_OR_POS];
		assign clause_now[c] = sel != '0 &&
			(use_or ? |(sel & ev_now) : &(ev_now | ~sel));
	end

	// every event and clause captured together on the sample enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_hit <= '0;
			clause_hit <= '0;
			prev_smp <= '0;
			prev_valid <= 1'b0;
		end else if (sample_en) begin
			event_hit <= ev_now;
			clause_hit <= clause_now;
			prev_smp <= smp;
			prev_valid <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sample_hs;
		sample_en && hs_mode;
	endsequence
	property p_range_off;
		s_sample_hs |=> !event_hit[ter_pkg::EV_RANGE];
	endproperty
	a_range_off: assert property (p_range_off)
		else $error("range event true in high-speed timing");

	property p_anything;
		sample_en |=> event_hit[ter_pkg::EV_ANY];
	endproperty
	a_anything: assert property (p_anything)
		else $error("anything event not true after sample");

	property p_hold;
		!sample_en |=> $stable(event_hit) && $stable(clause_hit);
	endproperty
	a_hold: assert property (p_hold)
		else $error("results changed without a sample");

	property p_chan_dc;
		sample_en && chan_cond == ter_pkg::LV_DONT_CARE |=> event_hit[ter_pkg::EV_CHAN];
	endproperty
	a_chan_dc: assert property (p_chan_dc)
		else $error("don't-care channel event was false");

	property p_flag_set;
		sample_en && flag_cond == ter_pkg::LV_ASSERTED
			|=> event_hit[ter_pkg::EV_FLAG] == $past(trig_flag);
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("flag set event does not follow flag");

	property p_cnt_ge;
		sample_en && !mode_cfg[ter_pkg::CNT_LT_POS] && cnt_val0 >= cnt_tgt[0]
			|=> event_hit[ter_pkg::EV_CNT0];
	endproperty
	a_cnt_ge: assert property (p_cnt_ge)
		else $error("counter at target not reported");

	property p_tmr_lt;
		sample_en && mode_cfg[ter_pkg::TMR_LT_POS] && tmr_val0 >= tmr_tgt[0]
			|=> !event_hit[ter_pkg::EV_TMR0];
	endproperty
	a_tmr_lt: assert property (p_tmr_lt)
		else $error("timer below-target event wrongly true");

	property p_range_bounds;
		sample_en && !hs_mode && range_op == ter_pkg::RG_IN
			&& (range_val == range_lim1 || range_val == range_lim2)
			|=> event_hit[ter_pkg::EV_RANGE];
	endproperty
	a_range_bounds: assert property (p_range_bounds)
		else $error("value at a range bound not inside");

	property p_clause_or;
		sample_en && clause_cfg[0][ter_pkg::CLAUSE_OR_POS]
			&& (clause_cfg[0][ter_pkg::EV_N-1:0] & ev_now) != '0 |=> clause_hit[0];
	endproperty
	a_clause_or: assert property (p_clause_or)
		else $error("or clause missed a true event");

	property p_wr_resp;
		do_write |=> s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write response did not follow");
endmodule

// *** design/ter_word_cmp.sv ***
// one masked word comparator over address, data and control channels
module ter_word_cmp (
	// clock and reset, used by the checks only
	input wire logic aclk,
	input wire logic aresetn,
	// sample and target
	input wire ter_pkg::ter_sample_t smp,
	input wire ter_pkg::ter_sample_t target,
	input wire ter_pkg::ter_sample_t care,
	input wire logic ne,
	// combinational result
	output logic hit
);
	// a care bit of zero is a don't-care digit
	wire match = ((smp ^ target) & care) == '0;
	assign hit = match ^ ne;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_dont_care;
		care == '0 |-> hit == !ne;
	endproperty
	a_dont_care: assert property (p_dont_care)
		else $error("all don't-care word did not match");

	property p_word_equal;
		(care != '0) && ((smp & care) == (target & care)) |-> hit != ne;
	endproperty
	a_word_equal: assert property (p_word_equal)
		else $error("masked equal word gave wrong result");
endmodule

// *** sim/ter_probe_model.sv ***
// probe model: the probed channels of the system under test
module ter_probe_model (
	// clock
	input wire logic aclk,
	// request from the bench
	input wire ter_pkg::ter_sample_t want,
	input wire logic fire,
	// probed channels toward the block
	output ter_pkg::ter_sample_t smp,
	output logic sample_en
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		smp = '0;
		sample_en = 1'b0;
	end
	// lines toggle outside samples so stale data never looks valid
	always @(posedge aclk) begin
		sample_en <= fire;
		smp <= fire ? want : ~smp;
	end
endmodule

// *** sim/ter_recognizer_test.sv ***
// self-checking bench of the trigger event recognizer
module ter_recognizer_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] ok = ter_pkg::RESP_OKAY;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic awready, wready, bvalid, arready, rvalid, sample_en;
	logic [1:0] bresp, rresp;
	logic trig_flag = 1'b0, fire = 1'b0;
	logic [3:0] mod_sig = 4'h0;
	logic [31:0] cnt_val0 = 32'h0, cnt_val1 = 32'h0, tmr_val0 = 32'h0, tmr_val1 = 32'h0;
	ter_pkg::ter_sample_t want = '0, smp;
	logic [ter_pkg::EV_N-1:0] event_hit;
	logic [ter_pkg::CLAUSE_N-1:0] clause_hit;
	int mismatches = 0, n_compared = 0, cycles = 0;

	ter_recognizer i_ter_recognizer (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .smp(smp), .sample_en(sample_en), .trig_flag(trig_flag),
		.mod_sig(mod_sig), .cnt_val0(cnt_val0), .cnt_val1(cnt_val1), .tmr_val0(tmr_val0),
		.tmr_val1(tmr_val1), .event_hit(event_hit), .clause_hit(clause_hit)
	);
	ter_probe_model i_ter_probe_model (
		.aclk(aclk), .want(want), .fire(fire), .smp(smp), .sample_en(sample_en)
	);

	// clock and hang guard
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	// handshakes judged 1 ns after each edge, once the block has settled
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			#1;
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			if (tb) chk("bresp", 32'(er), 32'(bresp));
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, tr;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			#1;
			ta = arvalid && arready;
			tr = rvalid;
			if (tr) chk("rdata", e, rdata);
			if (tr) chk("rresp", 32'(er), 32'(rresp));
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	// one sample; results land at the edge after sample_en
	task automatic take(input ter_pkg::ter_sample_t v);
		@(posedge aclk);
		fire <= 1'b1;
		want <= v;
		@(posedge aclk);
		fire <= 1'b0;
		@(posedge aclk);
		#1;
	endtask

	task automatic t_word();
		take({64'h0, 32'h1234_ABCD});
		chk("word dflt", 32'hF, 32'(event_hit[3:0]));
		chk("anything", 32'h1, 32'(event_hit[13]));
		wr(12'h0A0, 32'h1234_0000, ok);
		wr(12'h0AC, 32'hFFFF_0000, ok);
		take({64'h0, 32'h1234_ABCD});
		chk("word hit", 32'hF, 32'(event_hit[3:0]));
		take({64'h0, 32'h1235_ABCD});
		chk("word miss", 32'hD, 32'(event_hit[3:0]));
		wr(12'h000, 32'h1800_0000, ok);
		take({64'h0, 32'h1235_ABCD});
		chk("word ne", 32'hE, 32'(event_hit[3:0]));
	endtask
	task automatic t_regs();
		rd(12'h008, 32'hFFFF_FFFF, ok);
		rd(12'h014, 32'h0000_0001, ok);
		rd(12'h01C, 32'h0000_0007, ok);
		rd(12'h098, 32'h0000_0000, ter_pkg::RESP_SLVERR);
		wr(12'h01C, 32'hFFFF_FFFF, ok);
		rd(12'h01C, 32'hFFFF_FFFF, ok);
	endtask
	task automatic t_range();
		// 0x180 against limits given high first: per-operator outcome
		logic [7:0] exp;
		exp = 8'hC9;
		wr(12'h004, 32'h0000_0200, ok);
		wr(12'h008, 32'h0000_0100, ok);
		for (int op = 0; op < 8; op++) begin
			wr(12'h000, 32'(op), ok);
			take({64'h0, 32'h0000_0180});
			chk("range", 32'(exp[op]), 32'(event_hit[4]));
		end
		// data section as source, value sitting right on a bound
		wr(12'h000, 32'h0000_0008, ok);
		take({32'h0, 32'h0000_0100, 32'h0});
		chk("range bound", 32'h1, 32'(event_hit[4]));
		wr(12'h000, 32'h0000_0010, ok);
		take({64'h0, 32'h0000_0180});
		chk("range fast", 32'h0, 32'(event_hit[4]));
	endtask
	task automatic t_misc();
		logic [31:0] m;
		wr(12'h010, 32'h0000_0005, ok);
		wr(12'h014, 32'h0000_0005, ok);
		trig_flag <= 1'b1;
		mod_sig <= 4'h4;
		cnt_val0 <= 32'h0000_0005;
		cnt_val1 <= 32'h0000_0004;
		tmr_val0 <= 32'h0000_0007;
		tmr_val1 <= 32'hFFFF_FFFE;
		// same condition code for channel 40, flag, signal 2; less-than on odd codes
		for (int c = 0; c < 3; c++) begin
			m = 32'(c) * 32'h0004_5000 | 32'h0002_0500 | {32{c[0]}} & 32'h0780_0000;
			wr(12'h000, m, ok);
			take({32'h0, 32'h0000_0100, 32'h0});
			chk("chan", 32'(c != 1), 32'(event_hit[5]));
			chk("flag", 32'(c != 1), 32'(event_hit[10]));
			chk("signal", 32'(c != 1), 32'(event_hit[11]));
			chk("cnt tmr", c[0] ? 32'hA : 32'h5, 32'(event_hit[9:6]));
		end
	endtask
	task automatic t_consec();
		wr(12'h000, 32'h0000_0000, ok);
		take({32'hA5, 64'h0});
		take({32'hA5, 64'h0});
		chk("consec eq", 32'h1, 32'(event_hit[12]));
		take({32'hA4, 64'h0});
		chk("consec diff", 32'h0, 32'(event_hit[12]));
		wr(12'h000, 32'h0040_0000, ok);
		take({32'hA4, 64'h0});
		chk("consec ne", 32'h0, 32'(event_hit[12]));
		take({32'hA5, 64'h0});
		chk("consec ne", 32'h1, 32'(event_hit[12]));
		// groups with empty masks see nothing change
		wr(12'h000, 32'h0010_0000, ok);
		take({32'hA4, 64'h0});
		chk("consec groups", 32'h1, 32'(event_hit[12]));
		wr(12'h028, 32'h0000_0001, ok);
		take({32'hA5, 64'h0});
		chk("consec groups", 32'h0, 32'(event_hit[12]));
		// one group on the data section ignores the control change
		wr(12'h000, 32'h0020_0008, ok);
		take({32'hA4, 64'h0});
		chk("consec group", 32'h1, 32'(event_hit[12]));
	endtask
	task automatic t_clause();
		wr(12'h040, 32'h0001_2010, ok);
		wr(12'h044, 32'h0000_2010, ok);
		wr(12'h000, 32'h0000_0010, ok);
		take('0);
		chk("clause", 32'h01, 32'(clause_hit));
		wr(12'h000, 32'h0000_0001, ok);
		take('0);
		chk("clause", 32'h03, 32'(clause_hit));
		// status mirrors both result vectors and refuses writes
		rd(12'h02C, 32'h0003_355D, ok);
		wr(12'h02C, 32'h0000_0000, ter_pkg::RESP_SLVERR);
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// reset, then the scenarios in order
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_word();
		t_regs();
		t_range();
		t_misc();
		t_consec();
		t_clause();
		end_sim();
	end
endmodule
